/* File: dv/ssw_cpu_model.sv */
`timescale 1ns/1ns
// Processor side: strobes the watchdog and tallies fault pulses
module ssw_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Strobe control and fault pin
  input  wire logic       kickOn,
  input  wire logic [7:0] gapCycles,
  input  wire logic       faultN,
  // Strobe pin and fault tally
  output logic            kick,
  output logic [7:0]      faultCount
);
  logic [7:0] gap;
  logic       faultLast;
  logic       due;

  // Strobe stands still while stopped, so a hang really times out
  assign due = kickOn && (gap >= gapCycles);

  // Toggle once per gap, count falling fault edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap        <= 8'h00;
      kick       <= 1'b0;
      faultLast  <= 1'b0;
      faultCount <= 8'h00;
    end else begin
      gap       <= due ? 8'h00 : gap + 8'h01;
      kick      <= due ? ~kick : kick;
      faultLast <= faultN;
      if (faultLast && !faultN) begin
        faultCount <= faultCount + 8'h01;
      end
    end
  end
endmodule : ssw_cpu_model

/* File: dv/tb_supply_supervisor_watchdog.sv */
`timescale 1ns/1ns
module tb_supply_supervisor_watchdog;
  localparam int TC = 4;
  localparam int FT = 5;
  localparam int FLT = ssw_pkg::ALERT_FILTER_CYCLES;
  localparam int PLS = ssw_pkg::ALERT_PULSE_CYCLES;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } ssw_exp_t;
  logic        clk, rst_n, psel, penable, pwrite, kick, kickOn, mpbN, monOk;
  logic        pready, pslverr, faultN, alertAN, alertBN, flagN, irq;
  logic [1:0]  sense, perSel, supRstN;
  logic [7:0]  paddr, gapCyc, faultCnt;
  logic [31:0] pwdata, prdata;
  wire  [3:0]  pins = {flagN, alertBN, alertAN, faultN};
  int          errTotal, numChecks, seed, cyc, n, m, t;
  ssw_exp_t    q[$];
  ssw_exp_t    e;

  ssw_supervisor #(.TICK_CYC(TC), .WD_SHORT(20), .WD_MID(40),
    .WD_LONG(80), .FAULT_TICKS(FT), .MPB_TICKS(3)) DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdogKick(kick),
    .watchdogPeriodSelect(perSel), .masterManualResetN(mpbN),
    .supplyResetN(supRstN), .supplyMonitorOk(monOk),
    .auxSenseA(sense[0]), .auxSenseB(sense[1]),
    .watchdogFaultN(faultN), .auxAlertAN(alertAN), .auxAlertBN(alertBN),
    .lastResetSourceFlagN(flagN), .irq(irq));

  ssw_cpu_model cpu (.clk(clk), .rst_n(rst_n), .kickOn(kickOn),
    .gapCycles(gapCyc), .faultN(faultN), .kick(kick),
    .faultCount(faultCnt));

  // Free-running bench clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out;
    if (errTotal == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the expectation goes to the scoreboard queue
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] ed, input logic [31:0] em,
    input logic ee);
    @(posedge clk);
    q.push_back('{ed, em, ee});
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [31:0] em);
    apb(1'b0, a, 32'h0, ed, em, 1'b0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle

  // Bounded wait for an output pin to reach a level
  task automatic waitPin(input int i, input logic v, input int lim,
    output int k);
    k = 0;
    while (pins[i] !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) chk(pins[i], v);
  endtask : waitPin

  // Scoreboard: oldest note against each completed transfer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) chk(32'h0, 32'h1);
      else begin
        e = q.pop_front();
        chk(prdata & e.mask, e.data & e.mask);
        chk(pslverr, e.err);
      end
    end
  end

  // Hang guard, well past the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errTotal++;
      close_out();
    end
  end

  initial begin
    seed    = 47;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    kickOn  = 1'b0;
    gapCyc  = 8'h14;
    mpbN    = 1'b1;
    monOk   = 1'b0;
    sense   = 2'h3;
    perSel  = 2'h0;
    supRstN = 2'h0;
    idle(6);
    rst_n <= 1'b1;
    idle(10);
    chk(pins, 4'h0);
    rd(ssw_pkg::OFS_STATUS, 32'h0, 32'h0000_000F);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(ssw_pkg::OFS_INT_MASK, 32'hF);
    rd(ssw_pkg::OFS_INT_MASK, 32'hF, 32'hFFFF_FFFF);
    monOk <= 1'b1;
    idle(300);
    chk(pins, 4'hF);
    rd(ssw_pkg::OFS_WD_COUNT, 32'h0, 32'hFFFF_FFFF);
    // Random strobe gaps, all inside the shortest period
    supRstN <= 2'h3;
    kickOn  <= 1'b1;
    repeat (20) begin
      gapCyc <= 8'(10 + {$random(seed)} % 50);
      idle(40);
    end
    chk(faultCnt, 8'h0);
    rd(ssw_pkg::OFS_INT_STAT, 32'h0, 32'h1);
    // Starved strobe: period per select code, pulse and restart
    kickOn <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      perSel <= 2'(s);
      t = (s == 0) ? 20 : (s == 1) ? 40 : 80;
      waitPin(0, 1'b0, 2000, n);
      waitPin(0, 1'b1, 200, n);
      waitPin(0, 1'b0, 2000, n);
      chk(n >= t * TC && n <= (t + 2) * TC + 4, 1);
      waitPin(0, 1'b1, 200, m);
      chk(m >= FT * TC, 1);
    end
    idle(2);
    chk(irq, 1'b1);
    chk(faultCnt, 8'h06);
    kickOn <= 1'b1;
    idle(100);
    wr(ssw_pkg::OFS_INT_MASK, 32'hE);
    idle(2);
    chk(irq, 1'b0);
    wr(ssw_pkg::OFS_INT_MASK, 32'hF);
    idle(2);
    chk(irq, 1'b1);
    wr(ssw_pkg::OFS_INT_STAT, 32'hF);
    idle(2);
    chk(irq, 1'b0);
    // Alerts: noise dip, then short and long real dips
    for (int c = 0; c < 2; c++) begin
      sense[c] <= 1'b0;
      idle(20 + {$random(seed)} % 200);
      sense[c] <= 1'b1;
      idle(300);
      chk(pins[c + 1], 1'b1);
      for (int d = 20; d <= 1400; d += 1380) begin
        sense[c] <= 1'b0;
        waitPin(c + 1, 1'b0, 400, n);
        chk(n >= FLT && n <= FLT + 8, 1);
        idle(d);
        chk(pins[c + 1], 1'b0);
        sense[c] <= 1'b1;
        waitPin(c + 1, 1'b1, 1400, m);
        chk(d + m >= PLS, 1);
        if (d > PLS) chk(m <= 8, 1);
      end
    end
    rd(ssw_pkg::OFS_INT_STAT, 32'h6, 32'h6);
    wr(ssw_pkg::OFS_INT_STAT, 32'hF);
    // Master manual reset: glitch, then a real press
    perSel <= 2'h0;
    idle(300);
    mpbN <= 1'b0;
    idle(8);
    mpbN <= 1'b1;
    idle(30);
    chk(pins[3], 1'b1);
    rd(ssw_pkg::OFS_INT_STAT, 32'h0, 32'h8);
    mpbN <= 1'b0;
    idle(40);
    chk(pins, 4'h0);
    mpbN <= 1'b1;
    idle(20);
    chk(pins, 4'h0);
    idle(200);
    chk(pins[3], 1'b0);
    rd(ssw_pkg::OFS_INT_STAT, 32'h8, 32'h8);
    supRstN <= 2'h2;
    idle(10);
    chk(pins[3], 1'b1);
    supRstN <= 2'h3;
    // Second reset mid-run forces outputs again
    rst_n <= 1'b0;
    idle(2);
    chk(pins, 4'h0);
    rst_n <= 1'b1;
    idle(5);
    close_out();
  end
endmodule : tb_supply_supervisor_watchdog

/* File: hdl/placeholder_unused.sv */
`timescale 1ns/1ns

/* File: hdl/ssw_alert.sv */
`timescale 1ns/1ns
module ssw_alert #(
  parameter int FILTER = ssw_pkg::ALERT_FILTER_CYCLES,
  parameter int PULSE  = ssw_pkg::ALERT_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Synchronised comparator, high above trip level
  input  wire logic senseHigh,
  // Alert level and one-cycle assert event
  output logic      alertN,
  output logic      assertEvt
);
  localparam int FW = $clog2(FILTER + 1);
  localparam int PW = $clog2(PULSE + 1);

  typedef struct packed {
    logic [FW-1:0] lowCnt;
    logic [PW-1:0] pulseCnt;
    logic          alertN;
    logic          evt;
  } ssw_alert_state_t;

  ssw_alert_state_t s;
  ssw_alert_state_t next_s;
  logic             below;
  logic             newAssert;

  // Filter dips, then stretch the first low into a full pulse
  always_comb begin
    next_s = s;
    below = !senseHigh && (s.lowCnt >= FW'(FILTER - 1));
    newAssert = below && s.alertN && (s.pulseCnt == '0);
    if (senseHigh) begin
      next_s.lowCnt = '0;
    end else if (s.lowCnt != FW'(FILTER)) begin
      next_s.lowCnt = s.lowCnt + FW'(1);
    end
    if (newAssert) begin
      next_s.pulseCnt = PW'(PULSE - 1);
    end else if (s.pulseCnt != '0) begin
      next_s.pulseCnt = s.pulseCnt - PW'(1);
    end
    // Low while below trip, and never shorter than the pulse
    next_s.alertN = !(below || newAssert || s.pulseCnt != '0);
    next_s.evt = newAssert;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{lowCnt: '0, pulseCnt: '0, alertN: 1'b1, evt: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign alertN = s.alertN;
  assign assertEvt = s.evt;

  // Helper: length of the current low pulse
  logic [PW:0] lowLen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowLen <= '0;
    end else begin
      lowLen <= s.alertN ? '0 : lowLen + (PW + 1)'(1);
    end
  end

  a_alert_width: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(s.alertN) |-> lowLen >= (PW + 1)'(PULSE))
    else $error("alert pulse too short");
  a_alert_filter: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(s.alertN) |-> $past(s.lowCnt) >= FW'(FILTER - 1))
    else $error("alert asserted before filter time");
  a_alert_below: assert property (
    @(posedge clk) disable iff (!rst_n)
    !senseHigh && s.lowCnt == FW'(FILTER) |=> !s.alertN)
    else $error("alert released while input below trip");

endmodule : ssw_alert

/* File: hdl/ssw_supervisor.sv */
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Contract
// - A master manual reset drives the last-reset flag low until another reset source clears it.
// - Once cleared the flag stays high until the next master manual reset.
// - Without an accurate monitoring supply every supervisory output is held active.
// - A sense input reaching its trip level pulses its alert low for at least 10 us.
// - An alert asserts only after the input stays below trip for about 2 us.
// - An alert stays low while its input is below trip and is released above it.
// - Alerts stay active at power-up until a supply reaches the monitoring threshold.
// - The fault output goes low when the strobe shows no edge within the timeout.
// - The period select gives least timeouts of 10 ms, 100 ms or 1000 ms.
// - The watchdog counts only while at least one supply reset is inactive.
// - Any strobe edge before timeout restarts the count from zero.
// - A timeout pulses the fault output low for at least 100 us.
// - The watchdog cannot be disabled once running.
// - A master reset held 20 us forces all outputs active while held and a delay after.
module ssw_supervisor #(
  parameter int TICK_CYC    = ssw_pkg::TICK_CYCLES,
  parameter int WD_SHORT    = ssw_pkg::WD_SHORT_TICKS,
  parameter int WD_MID      = ssw_pkg::WD_MID_TICKS,
  parameter int WD_LONG     = ssw_pkg::WD_LONG_TICKS,
  parameter int FAULT_TICKS = ssw_pkg::FAULT_PULSE_TICKS,
  parameter int MPB_TICKS   = ssw_pkg::MPB_MIN_TICKS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from the outside, asynchronous
  input  wire logic        watchdogKick,
  input  wire logic [1:0]  watchdogPeriodSelect,
  input  wire logic        masterManualResetN,
  input  wire logic [1:0]  supplyResetN,
  input  wire logic        supplyMonitorOk,
  input  wire logic        auxSenseA,
  input  wire logic        auxSenseB,
  // Supervisory outputs, active low
  output logic             watchdogFaultN,
  output logic             auxAlertAN,
  output logic             auxAlertBN,
  output logic             lastResetSourceFlagN,
  // Interrupt
  output logic             irq
);
  localparam int TCW = $clog2(TICK_CYC);
  localparam int CW  = ssw_pkg::WD_CNT_W;
  localparam int MW  = $clog2(MPB_TICKS + 1);

  typedef struct packed {
    logic [ssw_pkg::SY_W-1:0] sync0;
    logic [ssw_pkg::SY_W-1:0] sync1;
    logic                     kickPrev;
    logic [1:0]               rstPrev;
    logic [TCW-1:0]           tickCnt;
    logic                     tick;
    logic [MW-1:0]            mpbCnt;
    logic                     mpbActive;
    logic [CW-1:0]            holdCnt;
    logic                     mpbHold;
    logic                     flag;
    ssw_pkg::ssw_evt_t        intStat;
    ssw_pkg::ssw_evt_t        intMask;
    logic                     irq;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     wdFaultN;
    logic [1:0]               alertN;
    logic                     flagN;
  } ssw_top_state_t;

  ssw_top_state_t s;
  ssw_top_state_t next_s;

  // Period pin decode, shared by watchdog and master hold
  function automatic logic [CW-1:0] selTicks(input logic [1:0] code);
    case (code)
      ssw_pkg::PSEL_GND:   selTicks = CW'(WD_SHORT);
      ssw_pkg::PSEL_FLOAT: selTicks = CW'(WD_MID);
      default:             selTicks = CW'(WD_LONG);
    endcase
  endfunction : selTicks

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == ssw_pkg::OFS_STATUS) ||
             (addr == ssw_pkg::OFS_INT_STAT) ||
             (addr == ssw_pkg::OFS_INT_MASK) ||
             (addr == ssw_pkg::OFS_WD_COUNT);
  endfunction : mapped

  // Alert channels, index 0 is sense A
  logic [1:0]    alertRaw;
  logic [1:0]    alertEvt;
  logic          wdFaultRaw;
  logic          wdEvt;
  logic [CW-1:0] wdCount;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gAlert
      ssw_alert uAlert (
        .clk       (clk),
        .rst_n     (rst_n),
        .senseHigh (s.sync1[ssw_pkg::SY_SENSE + g]),
        .alertN    (alertRaw[g]),
        .assertEvt (alertEvt[g])
      );
    end
  endgenerate

  ssw_watchdog #(
    .FAULT_TICKS (FAULT_TICKS)
  ) uWatchdog (
    .clk         (clk),
    .rst_n       (rst_n),
    .tick        (s.tick),
    .kickEdge    (s.sync1[ssw_pkg::SY_KICK] ^ s.kickPrev),
    .running     (|s.sync1[ssw_pkg::SY_RST +: 2]),
    .periodTicks (selTicks(s.sync1[ssw_pkg::SY_PSEL +: 2])),
    .faultN      (wdFaultRaw),
    .timeoutEvt  (wdEvt),
    .count       (wdCount)
  );

  logic              mpbLow;
  logic              pressNow;
  logic              otherRst;
  logic              forceAll;
  logic              setup;
  logic              access;
  logic [31:0]       rdVal;
  ssw_pkg::ssw_evt_t evt;
  ssw_pkg::ssw_evt_t clr;

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    // Two-flop synchroniser on every pin
    next_s.sync0 = {watchdogPeriodSelect, watchdogKick, masterManualResetN,
                    supplyResetN, supplyMonitorOk, auxSenseB, auxSenseA};
    next_s.sync1 = s.sync0;
    next_s.kickPrev = s.sync1[ssw_pkg::SY_KICK];
    next_s.rstPrev = s.sync1[ssw_pkg::SY_RST +: 2];

    // Free-running 1 us time base
    next_s.tick = (s.tickCnt == TCW'(TICK_CYC - 1));
    next_s.tickCnt = next_s.tick ? '0 : s.tickCnt + TCW'(1);

    // Master button accepted only after the least low time
    mpbLow = !s.sync1[ssw_pkg::SY_MPB];
    pressNow = mpbLow && s.tick && (s.mpbCnt == MW'(MPB_TICKS - 1));
    if (!mpbLow) begin
      next_s.mpbCnt = '0;
    end else if (s.tick && s.mpbCnt != MW'(MPB_TICKS)) begin
      next_s.mpbCnt = s.mpbCnt + MW'(1);
    end
    next_s.mpbActive = mpbLow && (s.mpbActive || pressNow);
    // Hold outputs active for the selected delay after release
    if (next_s.mpbActive) begin
      next_s.holdCnt = selTicks(s.sync1[ssw_pkg::SY_PSEL +: 2]);
    end else if (s.tick && s.holdCnt != '0) begin
      next_s.holdCnt = s.holdCnt - CW'(1);
    end
    next_s.mpbHold = next_s.mpbActive || (next_s.holdCnt != '0);

    // Master forces the supply resets too, so those falls are ignored
    otherRst = |(s.rstPrev & ~s.sync1[ssw_pkg::SY_RST +: 2]) && !s.mpbHold;
    if (pressNow) begin
      next_s.flag = 1'b0;
    end else if (otherRst) begin
      next_s.flag = 1'b1;
    end

    // Every supervisory output active without monitoring supply or under master
    forceAll = !s.sync1[ssw_pkg::SY_MON] || s.mpbHold;
    next_s.wdFaultN = wdFaultRaw && !forceAll;
    next_s.alertN = alertRaw & {2{!forceAll}};
    next_s.flagN = s.flag && !forceAll;

    // APB: answer in the first access cycle
    setup = psel && !penable;
    access = psel && penable && s.pready;
    next_s.pready = setup;
    next_s.pslverr = setup && !mapped(paddr);
    rdVal = '0;
    case (paddr)
      ssw_pkg::OFS_STATUS: begin
        rdVal[ssw_pkg::STAT_WDF] = s.wdFaultN;
        rdVal[ssw_pkg::STAT_ALA] = s.alertN[0];
        rdVal[ssw_pkg::STAT_ALB] = s.alertN[1];
        rdVal[ssw_pkg::STAT_FLAG] = s.flagN;
        rdVal[ssw_pkg::STAT_MONOK] = s.sync1[ssw_pkg::SY_MON];
        rdVal[ssw_pkg::STAT_HOLD] = s.mpbHold;
        rdVal[ssw_pkg::STAT_PSEL +: 2] = s.sync1[ssw_pkg::SY_PSEL +: 2];
      end
      ssw_pkg::OFS_INT_STAT: rdVal[3:0] = s.intStat;
      ssw_pkg::OFS_INT_MASK: rdVal[3:0] = s.intMask;
      ssw_pkg::OFS_WD_COUNT: rdVal[CW-1:0] = wdCount;
      default: rdVal = '0;
    endcase
    if (setup) begin
      next_s.prdata = rdVal;
    end

    // Sticky events, write one to clear, a new event wins
    clr = '0;
    if (access && pwrite && !s.pslverr) begin
      if (paddr == ssw_pkg::OFS_INT_STAT) begin
        clr = pwdata[3:0];
      end
      if (paddr == ssw_pkg::OFS_INT_MASK) begin
        next_s.intMask = pwdata[3:0];
      end
    end
    evt = {pressNow, alertEvt[1], alertEvt[0], wdEvt};
    next_s.intStat = (s.intStat & ~clr) | evt;
    next_s.irq = |(next_s.intStat & next_s.intMask);
  end

  // Pins idle high at reset, monitor low, so no edge is seen on release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.sync0 <= ssw_pkg::SYNC_IDLE; // No false release after reset
      s.sync1 <= ssw_pkg::SYNC_IDLE;
      s.kickPrev <= 1'b1;
      s.rstPrev <= 2'h3;
      s.flag <= 1'b1;
      s.intStat <= ssw_pkg::INT_STAT_RST;
      s.intMask <= ssw_pkg::INT_MASK_RST;
      s.wdFaultN <= 1'b0;
      s.alertN <= 2'h0;
      s.flagN <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign watchdogFaultN = s.wdFaultN;
  assign auxAlertAN = s.alertN[0];
  assign auxAlertBN = s.alertN[1];
  assign lastResetSourceFlagN = s.flagN;
  assign irq = s.irq;

  a_flag_master: assert property (
    @(posedge clk) disable iff (!rst_n)
    pressNow |=> !s.flag ##1 !s.flagN)
    else $error("master reset did not drive flag low");
  a_flag_stays: assert property (
    @(posedge clk) disable iff (!rst_n)
    s.flag && !pressNow |=> s.flag)
    else $error("flag fell without a master reset");
  a_no_monitor: assert property (
    @(posedge clk) disable iff (!rst_n)
    !s.sync1[ssw_pkg::SY_MON] |=> !s.wdFaultN && !s.flagN)
    else $error("outputs not forced without monitor supply");
  a_powerup_alert: assert property (
    @(posedge clk) disable iff (!rst_n)
    !s.sync1[ssw_pkg::SY_MON] |=> s.alertN == 2'h0)
    else $error("alert released before monitor threshold");
  a_master_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(s.mpbActive) |=> s.mpbHold && !s.wdFaultN && s.alertN == 2'h0)
    else $error("outputs released at master button release");
  a_time_base: assert property (
    @(posedge clk) disable iff (!rst_n)
    s.tick |=> !s.tick)
    else $error("time base tick longer than one cycle");
  a_stat_set: assert property (@(posedge clk) disable iff (!rst_n)
    wdEvt |=> s.intStat.wdTimeout)
    else $error("timeout event lost");

  // Flag clear, master forcing, pins following watchdog and alert filters outside forcing, master event, APB answer
  a_flag_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    otherRst && !pressNow |=> s.flag)
    else $error("other reset did not clear flag");
  a_master_force: assert property (
    @(posedge clk) disable iff (!rst_n)
    s.mpbActive |=> !s.wdFaultN && !s.flagN && s.alertN == 2'h0)
    else $error("outputs not forced while master held");
  a_fault_pass: assert property (
    @(posedge clk) disable iff (!rst_n)
    !forceAll |=> s.wdFaultN == $past(wdFaultRaw))
    else $error("fault output does not follow watchdog");
  a_alert_pass: assert property (
    @(posedge clk) disable iff (!rst_n)
    !forceAll |=> s.alertN == $past(alertRaw))
    else $error("alert output does not follow filter");
  a_stat_master: assert property (
    @(posedge clk) disable iff (!rst_n)
    pressNow |=> s.intStat.master)
    else $error("master reset event lost");
  a_apb_answer: assert property (
    @(posedge clk) disable iff (!rst_n)
    psel && !penable |=> s.pready)
    else $error("setup cycle not answered");

endmodule : ssw_supervisor

/* File: hdl/ssw_watchdog.sv */
`timescale 1ns/1ns
module ssw_watchdog #(
  parameter int FAULT_TICKS = ssw_pkg::FAULT_PULSE_TICKS
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Time base, strobe edge and supervision
  input  wire logic                          tick,
  input  wire logic                          kickEdge,
  input  wire logic                          running,
  input  wire logic [ssw_pkg::WD_CNT_W-1:0]  periodTicks,
  // Fault level, timeout event, elapsed ticks
  output logic                               faultN,
  output logic                               timeoutEvt,
  output logic [ssw_pkg::WD_CNT_W-1:0]       count
);
  localparam int CW = ssw_pkg::WD_CNT_W;
  localparam int FW = $clog2(FAULT_TICKS + 2);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [FW-1:0] pulse;
    logic          faultN;
    logic          evt;
  } ssw_wd_state_t;

  ssw_wd_state_t s;
  ssw_wd_state_t next_s;

  // No enable bit exists: only the resets being active stop it
  always_comb begin
    next_s = s;
    next_s.evt = 1'b0;
    if (tick && s.pulse != '0) begin
      next_s.pulse = s.pulse - FW'(1);
    end
    next_s.faultN = (next_s.pulse == '0);
    if (!running) begin
      next_s.cnt = '0;
    end else if (kickEdge || s.pulse != '0) begin
      next_s.cnt = '0;
    end else if (tick) begin
      if (s.cnt >= periodTicks) begin
        // One spare tick guarantees the least period
        next_s.cnt = '0;
        next_s.pulse = FW'(FAULT_TICKS + 1);
        next_s.faultN = 1'b0;
        next_s.evt = 1'b1;
      end else begin
        next_s.cnt = s.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{cnt: '0, pulse: '0, faultN: 1'b1, evt: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign faultN = s.faultN;
  assign timeoutEvt = s.evt;
  assign count = s.cnt;

  // Helper: ticks seen during the fault pulse
  logic [FW-1:0] lowTicks;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowTicks <= '0;
    end else if (s.faultN) begin
      lowTicks <= '0;
    end else if (tick) begin
      lowTicks <= lowTicks + FW'(1);
    end
  end

  a_wd_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !running |=> s.cnt == '0 && s.faultN)
    else $error("watchdog counted with all resets active");
  a_wd_kick: assert property (
    @(posedge clk) disable iff (!rst_n)
    running && kickEdge && s.faultN |=> s.cnt == '0 && s.faultN)
    else $error("strobe edge did not restart watchdog");
  a_wd_timeout: assert property (
    @(posedge clk) disable iff (!rst_n)
    running && !kickEdge && tick && s.pulse == '0 && s.cnt == periodTicks
    |=> !s.faultN ##1 !s.faultN)
    else $error("watchdog missed its timeout");
  a_wd_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(s.faultN) |-> lowTicks >= FW'(FAULT_TICKS))
    else $error("fault pulse too short");

endmodule : ssw_watchdog

/* File: pkg/ssw_pkg.sv */
package ssw_pkg;

  // Clock and internal time base
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sense filter is approximate, so it rounds down
  localparam int ALERT_FILTER_NS     = 2000;
  localparam int ALERT_FILTER_CYCLES = ALERT_FILTER_NS / CLK_PERIOD_NS;
  // Least alert pulse, rounded up
  localparam int ALERT_PULSE_NS     = 10000;
  localparam int ALERT_PULSE_CYCLES =
    (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counts in time-base ticks
  localparam int FAULT_PULSE_US    = 100;
  localparam int FAULT_PULSE_TICKS =
    FAULT_PULSE_US * 1000 / TICK_PERIOD_NS;
  localparam int MPB_MIN_US    = 20;
  localparam int MPB_MIN_TICKS = MPB_MIN_US * 1000 / TICK_PERIOD_NS;
  localparam int WD_SHORT_MS    = 10;
  localparam int WD_MID_MS      = 100;
  localparam int WD_LONG_MS     = 1000;
  localparam int WD_SHORT_TICKS = WD_SHORT_MS * 1000000 / TICK_PERIOD_NS;
  localparam int WD_MID_TICKS   = WD_MID_MS * 1000000 / TICK_PERIOD_NS;
  localparam int WD_LONG_TICKS  = WD_LONG_MS * 1000000 / TICK_PERIOD_NS;
  localparam int WD_CNT_W       = 20;

  // Period select pin codes
  localparam logic [1:0] PSEL_GND   = 2'h0;
  localparam logic [1:0] PSEL_FLOAT = 2'h1;

  // Register offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_INT_STAT = 8'h04;
  localparam logic [7:0] OFS_INT_MASK = 8'h08;
  localparam logic [7:0] OFS_WD_COUNT = 8'h0C;

  // Status register fields
  localparam int STAT_WDF   = 0;
  localparam int STAT_ALA   = 1;
  localparam int STAT_ALB   = 2;
  localparam int STAT_FLAG  = 3;
  localparam int STAT_MONOK = 4;
  localparam int STAT_HOLD  = 5;
  localparam int STAT_PSEL  = 6;

  // Synchroniser bit positions
  localparam int SY_SENSE = 0;
  localparam int SY_MON   = 2;
  localparam int SY_RST   = 3;
  localparam int SY_MPB   = 5;
  localparam int SY_KICK  = 6;
  localparam int SY_PSEL  = 7;
  localparam int SY_W     = 9;
  // Synchroniser reset: pins idle high, monitor low keeps outputs forced
  localparam logic [SY_W-1:0] SYNC_IDLE = ~(SY_W'(1) << SY_MON);

  // Event bits, status and mask share this layout
  typedef struct packed {
    logic master;
    logic alertB;
    logic alertA;
    logic wdTimeout;
  } ssw_evt_t;

  localparam ssw_evt_t INT_MASK_RST = 4'h0;
  localparam ssw_evt_t INT_STAT_RST = 4'h0;

endpackage : ssw_pkg
